// ### design/skew_consts.vh
`ifndef SKEW_CONSTS_VH
`define SKEW_CONSTS_VH
`define COARSE_SKEW_ADDR 4'hE
`define FINE_SKEW_ADDR 4'hF
`define COARSE_SKEW_RESET 16'h07FF
`define FINE_SKEW_RESET 16'h007F
`define INPUT_SELECT_BIT 15
`define DIRECTION_BIT 14
`define COARSE_MSB 13
`define COARSE_LSB 11
`define FINE_MSB 15
`define FINE_LSB 7
`define COARSE_STEP_FS 20'h04E20
`define FINE_STEP_FS 20'h00064
`define RESTART_LATENCY 4'h3
`endif

// ### design/sync2.v
`timescale 1ns/100ps
module sync2
(
  input wire clk_in,
  input wire rst_b_in,
  input wire d_in,
  output reg q_out
);
  reg stage1;
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      stage1 <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule

// ### design/interleave_skew_and_output_data_clock_resync.v
`timescale 1ns/100ps
`include "skew_consts.vh"
module interleave_skew_and_output_data_clock_resync
(
  input wire clk_in,
  input wire rst_b_in,
  input wire reg_write_in,
  input wire [3:0] reg_addr_in,
  input wire [15:0] reg_data_in,
  input wire interleave_enable_in,
  input wire auto_phase_align_in,
  input wire sample_clock_in,
  input wire output_clock_resync_in,
  input wire double_rate_in,
  input wire output_edge_in,
  input wire calibration_running_in,
  output reg route_q_input_out,
  output reg interleave_active_out,
  output reg delay_q_channel_out,
  output reg [19:0] i_skew_fs_out,
  output reg [19:0] q_skew_fs_out,
  output reg output_data_clock_out,
  output reg resync_misuse_out
);
  reg [15:0] interleave_coarse_skew;
  reg [15:0] interleave_fine_skew;
  localparam ST_RUN = 4'b0001;
  localparam ST_HOLD = 4'b0010;
  localparam ST_ARM = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  reg sclk_prev;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] restart_count;
  reg [3:0] next_count;
  reg div_phase;
  reg next_div_phase;
  reg next_clock;
  reg [19:0] next_i_skew;
  reg [19:0] next_q_skew;
  wire sclk_s;
  wire resync_s;
  wire sclk_fall;
  wire [2:0] coarse_skew_magnitude;
  wire [8:0] fine_skew_magnitude;
  wire interleave_input_select;
  wire skew_direction_select;
  wire [19:0] coarse_fs;
  wire [19:0] fine_fs;
  wire [19:0] total_fs;
  wire hold_level;

  sync2 sclk_sync
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(sample_clock_in),
    .q_out(sclk_s)
  );

  sync2 resync_sync
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in(output_clock_resync_in),
    .q_out(resync_s)
  );

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      interleave_coarse_skew <= `COARSE_SKEW_RESET;
      interleave_fine_skew <= `FINE_SKEW_RESET;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == `COARSE_SKEW_ADDR)
        interleave_coarse_skew <= reg_data_in;
      if (reg_addr_in == `FINE_SKEW_ADDR)
        interleave_fine_skew <= reg_data_in;
    end
  end

  assign interleave_input_select = interleave_coarse_skew[`INPUT_SELECT_BIT];
  assign skew_direction_select = interleave_coarse_skew[`DIRECTION_BIT];
  assign coarse_skew_magnitude = interleave_coarse_skew[`COARSE_MSB:`COARSE_LSB];
  assign fine_skew_magnitude = interleave_fine_skew[`FINE_MSB:`FINE_LSB];
  // skew in femtoseconds
  assign coarse_fs = coarse_skew_magnitude * `COARSE_STEP_FS;
  assign fine_fs = fine_skew_magnitude * `FINE_STEP_FS;
  assign total_fs = (auto_phase_align_in || !interleave_enable_in) ? 20'h00000 :
                    coarse_fs + fine_fs;

  // only the chosen channel carries the skew, the other stays undelayed
  always @*
  begin
    if (skew_direction_select)
    begin
      next_i_skew = 20'h00000;
      next_q_skew = total_fs;
    end
    else
    begin
      next_i_skew = total_fs;
      next_q_skew = 20'h00000;
    end
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      route_q_input_out <= 1'b0;
      interleave_active_out <= 1'b0;
      delay_q_channel_out <= 1'b0;
      i_skew_fs_out <= 20'h00000;
      q_skew_fs_out <= 20'h00000;
    end
    else
    begin
      interleave_active_out <= interleave_enable_in;
      route_q_input_out <= interleave_enable_in & interleave_input_select;
      delay_q_channel_out <= skew_direction_select;
      i_skew_fs_out <= next_i_skew;
      q_skew_fs_out <= next_q_skew;
    end
  end

  assign sclk_fall = ~sclk_s & sclk_prev;
  // held level: sdr follows edge select, ddr holds the opposite
  assign hold_level = double_rate_in ? ~output_edge_in : output_edge_in;

  always @*
  begin
    next_state = state;
    next_count = restart_count;
    next_div_phase = div_phase;
    next_clock = output_data_clock_out;
    if (resync_s)
    begin
      // hold at once, whatever phase; this can cut a pulse short
      next_state = ST_HOLD;
      next_count = 4'h0;
      next_clock = hold_level;
    end
    else
    begin
      case (state)
        ST_HOLD:
        begin
          next_state = ST_ARM;
          next_clock = hold_level;
        end
        ST_ARM:
        begin
          next_clock = hold_level;
          if (sclk_fall)
          begin
            next_state = ST_WAIT;
            next_div_phase = 1'b0;
            next_count = `RESTART_LATENCY;
          end
        end
        ST_WAIT:
        begin
          next_clock = hold_level;
          next_count = restart_count - 4'h1;
          if (restart_count == 4'h1)
            next_state = ST_RUN;
        end
        ST_RUN:
        begin
          if (sclk_fall)
          begin
            next_div_phase = ~div_phase;
            if (double_rate_in || div_phase)
              next_clock = ~output_data_clock_out;
          end
        end
        default:
        begin
          next_state = ST_RUN;
        end
      endcase
    end
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      sclk_prev <= 1'b0;
      state <= ST_RUN;
      restart_count <= 4'h0;
      div_phase <= 1'b0;
      output_data_clock_out <= 1'b0;
      resync_misuse_out <= 1'b0;
    end
    else
    begin
      sclk_prev <= sclk_s;
      state <= next_state;
      restart_count <= next_count;
      div_phase <= next_div_phase;
      output_data_clock_out <= next_clock;
      resync_misuse_out <= resync_s & calibration_running_in;
    end
  end
endmodule

// ### verification/skew_chk_asserts.sv
`timescale 1ns/100ps
module skew_chk_asserts
(
  input wire clk_in, rst_b_in, interleave_enable_in, auto_phase_align_in,
  input wire output_clock_resync_in, double_rate_in, output_edge_in,
  input wire calibration_running_in, route_q_input_out, delay_q_channel_out,
  input wire [19:0] i_skew_fs_out,
  input wire [19:0] q_skew_fs_out,
  input wire output_data_clock_out, resync_misuse_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire odc = output_data_clock_out;
  wire rsy = output_clock_resync_in;
  a_q_skew_dir: assert property (q_skew_fs_out != 20'h0 |-> delay_q_channel_out)
    else $error("q skew wrong side");
  a_i_skew_dir: assert property (i_skew_fs_out != 20'h0 |-> !delay_q_channel_out)
    else $error("i skew wrong side");
  a_one_side: assert property (!(i_skew_fs_out != 20'h0 && q_skew_fs_out != 20'h0))
    else $error("both skewed");
  a_auto_zero: assert property (auto_phase_align_in[*3]
    |-> (i_skew_fs_out | q_skew_fs_out) == 20'h0) else $error("auto skew");
  a_il_off_zero: assert property (!interleave_enable_in[*3]
    |-> !route_q_input_out && (i_skew_fs_out | q_skew_fs_out) == 20'h0)
    else $error("il off");
  a_hold_level: assert property (rsy[*5] |-> odc == (double_rate_in ^ output_edge_in))
    else $error("hold level");
  a_restart_quiet: assert property ($fell(rsy) |=> $stable(odc)[*5])
    else $error("early restart");
  a_restart_bound: assert property ($fell(rsy) |-> ##[6:80] $changed(odc))
    else $error("no restart");
  a_misuse_flag: assert property ((rsy && calibration_running_in)[*4]
    |-> resync_misuse_out) else $error("misuse flag");
  cover property (q_skew_fs_out != 20'h0);
  cover property (rsy[*5]);
  cover property (resync_misuse_out);
endmodule

// ### verification/resync_ctrl.sv
`timescale 1ns/100ps
module resync_ctrl
(
  output reg sample_clock_out,
  output reg resync_out
);
  initial
  begin
    sample_clock_out = 1'b0;
    resync_out = 1'b0;
    #1.3;
    forever #24 sample_clock_out = ~sample_clock_out;
  end
  task pulse(input int hi);
    #($urandom % 40) resync_out = 1'b1;
    repeat (hi) @(posedge sample_clock_out);
    resync_out = 1'b0;
  endtask
endmodule

// ### verification/interleave_skew_and_output_data_clock_resync_tb_top.sv
`timescale 1ns/100ps
module interleave_skew_and_output_data_clock_resync_tb_top;
  reg clk_in = 1'b0, rst_b_in = 1'b0, reg_write_in = 1'b0, interleave_enable_in = 1'b1;
  reg auto_phase_align_in = 1'b0, double_rate_in = 1'b0, output_edge_in = 1'b0;
  reg calibration_running_in = 1'b0, w;
  reg [3:0] reg_addr_in = 4'h0;
  reg [15:0] reg_data_in = 16'h0000, ce, fe;
  wire sample_clock_in, output_clock_resync_in, route_q_input_out, delay_q_channel_out;
  wire output_data_clock_out, resync_misuse_out, interleave_active_out;
  wire [19:0] i_skew_fs_out, q_skew_fs_out;
  int num_errors = 0, tests_run = 0;
  resync_ctrl i_ctl(.sample_clock_out(sample_clock_in), .resync_out(output_clock_resync_in));
  interleave_skew_and_output_data_clock_resync i_dut(.*);
  initial forever #2 clk_in = ~clk_in;
  function [19:0] skew(input [15:0] c, input [15:0] f);
    skew = c[13:11] * 20'h4E20 + f[15:7] * 20'h64;
  endfunction
  task chk(input string n, input [19:0] e, input [19:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_reg(input [3:0] a, input [15:0] d);
    @(negedge clk_in);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_data_in = d;
    @(negedge clk_in);
    reg_write_in = 1'b0;
  endtask
  task chk_state;
    repeat (3) @(negedge clk_in);
    chk("route", {19'h0, ce[15]}, {19'h0, route_q_input_out});
    chk("dir", {19'h0, ce[14]}, {19'h0, delay_q_channel_out});
    chk("i_skew", ce[14] ? 20'h0 : skew(ce, fe), i_skew_fs_out);
    chk("q_skew", ce[14] ? skew(ce, fe) : 20'h0, q_skew_fs_out);
    chk("active", 20'h1, {19'h0, interleave_active_out});
  endtask
  task close_out;
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h5468CEBD));
    repeat (16) @(posedge clk_in);
    @(negedge clk_in) rst_b_in = 1'b1;
    ce = 16'h07FF;
    fe = 16'h007F;
    chk_state;
    for (int k = 0; k < 10; k++)
    begin
      ce = k ? $urandom : 16'hFFFF;
      fe = k ? $urandom : 16'hFFFF;
      wr_reg(4'hE, ce);
      wr_reg(4'hF, fe);
      wr_reg($urandom % 14, $urandom);
      chk_state;
    end
    @(negedge clk_in) auto_phase_align_in = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("auto", 20'h0, i_skew_fs_out | q_skew_fs_out);
    auto_phase_align_in = 1'b0;
    interleave_enable_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("il_off", 20'h0, i_skew_fs_out | q_skew_fs_out);
    chk("active", 20'h0, {19'h0, interleave_active_out});
    interleave_enable_in = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      @(negedge clk_in);
      {calibration_running_in, output_edge_in, double_rate_in} = m[2:0];
      i_ctl.pulse(2 + $urandom % 3);
      chk("hold", {19'h0, double_rate_in ^ output_edge_in}, {19'h0, output_data_clock_out});
      chk("misuse", {19'h0, calibration_running_in}, {19'h0, resync_misuse_out});
      w = output_data_clock_out;
      for (int t = 0; t < 100 && output_data_clock_out === w; t++) @(negedge clk_in);
      chk("restart", {19'h0, ~w}, {19'h0, output_data_clock_out});
      if (output_data_clock_out === w) close_out;
    end
    close_out;
  end
endmodule
bind interleave_skew_and_output_data_clock_resync skew_chk_asserts i_chk(.*);
